// *** lin_node_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module lin_node_model (
    input wire logic clk_in,
    input wire logic go_in,
    input wire logic brk_in,
    input wire logic [7:0] byte_in,
    output logic line_out,
    output logic busy_out
);
    logic [9:0] fr;
    initial begin
        line_out = 1'b1;
        busy_out = 1'b0;
    end
    always begin
        @(posedge clk_in);
        if (go_in) begin
            busy_out <= 1'b1;
            fr = brk_in ? 10'h000 : {1'b1, byte_in, 1'b0};
            for (int i = 0; i < (brk_in ? 13 : 10); i++) begin
                line_out <= (i < 10) ? fr[i] : 1'b0;
                repeat (16) @(posedge clk_in);
            end
            line_out <= 1'b1;
            repeat (16) @(posedge clk_in);
            busy_out <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** lin_uart_break_header_rx.sv ***
// Overview of operation
// - status read then data write clears flags
// - send break loads break character
// - breaks repeat, then one mark bit
// - enabling transmitter sends idle preamble first
// - re-enable mid-word sends preamble after word
// - toggling enable discards held byte
// - nonzero rx prescaler divides sixteenth rate
// - nonzero tx prescaler divides bit rate
// - lin slave disables baud generators
// - header select: break or identifier
// - break mode: zero data, flags set
// - header irq needs enable and cpu mask
// - resync measures synch, else break mode receives it
// - framing error except break in slave
// - id mode flags after whole header
// - synch measurement suspends data transfer
// - lin slave with check enables parity
// - second character after break is identifier
// - word length bit, ninth bit source
// - complete flag after stop, with irq
`timescale 1ns/1ps
`default_nettype none
`include "lin_uart_params.svh"
module lin_uart_break_header_rx (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [1:0] cpu_mask_in,
    input wire logic rxd_in,
    output logic [7:0] rdata_out,
    output logic txd_out,
    output logic irq_out
);
    lin_uart_pkg::bus_req_t req;
    assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

    logic [7:0] baud_r, ctrl1_r, ctrl2_r, ctrl3_r, rxdiv_r, txdiv_r;
    logic [7:0] rx_data_r, tx_hold_r;
    logic tx_empty_r, tx_done_r, rx_full_r, frame_err_r, par_err_r;
    logic status_seen_r, hold_valid_r;
    logic word9, lin_slave;
    assign word9 = ctrl1_r[`CTRL1_WORD9];
    assign lin_slave = ctrl3_r[`CTRL3_LINE] & ctrl3_r[`CTRL3_SLAVE];

    // baud ticks: 16x tick from baud register prescale, then extended divider
    logic [7:0] pre_r, os_r, txe_r, rxe_r;
    logic tick16, tx_bit_tick, rx_tick16;
    assign tick16 = (pre_r == 8'h00) && !lin_slave;
    always_ff @(posedge clk_in) begin
        if (srst_in || lin_slave || pre_r == 8'h00) begin
            pre_r <= {5'h00, baud_r[2:0]};
        end else begin
            pre_r <= pre_r - 8'h01;
        end
    end
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            os_r <= 8'h00;
        end else if (tick16) begin
            os_r <= (os_r == `OVERSAMPLE - 8'h01) ? 8'h00 : os_r + 8'h01;
        end
    end
    logic base_bit;
    assign base_bit = tick16 && (os_r == `OVERSAMPLE - 8'h01);
    always_ff @(posedge clk_in) begin
        if (srst_in || txdiv_r == 8'h00) begin
            txe_r <= 8'h00;
        end else if (base_bit) begin
            txe_r <= (txe_r >= txdiv_r - 8'h01) ? 8'h00 : txe_r + 8'h01;
        end
    end
    assign tx_bit_tick = base_bit && (txdiv_r == 8'h00 || txe_r >= txdiv_r - 8'h01);
    always_ff @(posedge clk_in) begin
        if (srst_in || rxdiv_r == 8'h00) begin
            rxe_r <= 8'h00;
        end else if (tick16) begin
            rxe_r <= (rxe_r >= rxdiv_r - 8'h01) ? 8'h00 : rxe_r + 8'h01;
        end
    end
    assign rx_tick16 = tick16 && (rxdiv_r == 8'h00 || rxe_r >= rxdiv_r - 8'h01);

    // register writes
    logic wr_data, rd_status, te_rise;
    assign wr_data = req.wr && req.addr == `ADDR_DATA;
    assign rd_status = req.rd && req.addr == `ADDR_STATUS;
    assign te_rise = req.wr && req.addr == `ADDR_CTRL2 && req.wdata[`CTRL2_TE] && !ctrl2_r[`CTRL2_TE];
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            baud_r <= 8'h00;
            ctrl1_r <= 8'h00;
            ctrl2_r <= 8'h00;
            rxdiv_r <= 8'h00;
            txdiv_r <= 8'h00;
        end else if (req.wr) begin
            unique case (req.addr)
                `ADDR_BAUD: baud_r <= req.wdata;
                `ADDR_CTRL1: ctrl1_r <= {1'b0, req.wdata[6:0]};
                `ADDR_CTRL2: ctrl2_r <= req.wdata;
                `ADDR_RXDIV: rxdiv_r <= req.wdata;
                `ADDR_TXDIV: txdiv_r <= req.wdata;
                default: ;
            endcase
        end
    end

    // transmitter
    lin_uart_pkg::tx_state_t tx_st_r;
    logic [9:0] tx_sh_r;
    logic [3:0] tx_cnt_r;
    logic preamble_pend_r, tx_word_end;
    logic [3:0] frame_len;
    assign frame_len = word9 ? 4'hb : 4'ha;
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            preamble_pend_r <= 1'b0;
        end else if (te_rise) begin
            preamble_pend_r <= 1'b1;
        end else if (tx_st_r == lin_uart_pkg::TX_PREAMBLE) begin
            preamble_pend_r <= 1'b0;
        end
    end
    assign tx_word_end = tx_bit_tick && tx_cnt_r == 4'h1;
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            tx_st_r <= lin_uart_pkg::TX_IDLE;
            tx_sh_r <= 10'h3ff;
            tx_cnt_r <= 4'h0;
            txd_out <= 1'b1;
        end else if (!ctrl2_r[`CTRL2_TE] && tx_st_r == lin_uart_pkg::TX_IDLE) begin
            txd_out <= 1'b1;
        end else begin
            unique case (tx_st_r)
                lin_uart_pkg::TX_IDLE: begin
                    txd_out <= 1'b1;
                    if (preamble_pend_r) begin
                        tx_st_r <= lin_uart_pkg::TX_PREAMBLE;
                        tx_cnt_r <= word9 ? `PREAMBLE_9 : `PREAMBLE_8;
                    end else if (ctrl2_r[`CTRL2_SBK]) begin
                        tx_st_r <= lin_uart_pkg::TX_BREAK;
                        tx_cnt_r <= frame_len;
                    end else if (hold_valid_r) begin
                        tx_st_r <= lin_uart_pkg::TX_SHIFT;
                        tx_sh_r <= {ctrl1_r[`CTRL1_NINTH], tx_hold_r, 1'b0};
                        tx_cnt_r <= frame_len + 4'h1;
                    end
                end
                lin_uart_pkg::TX_PREAMBLE: begin
                    txd_out <= 1'b1;
                    if (tx_word_end) tx_st_r <= lin_uart_pkg::TX_IDLE;
                    else if (tx_bit_tick) tx_cnt_r <= tx_cnt_r - 4'h1;
                end
                lin_uart_pkg::TX_SHIFT: begin
                    if (tx_bit_tick) begin
                        txd_out <= (tx_cnt_r <= 4'h2) ? 1'b1 : tx_sh_r[0];
                        tx_sh_r <= {1'b1, tx_sh_r[9:1]};
                        tx_cnt_r <= tx_cnt_r - 4'h1;
                        if (tx_cnt_r == 4'h1) tx_st_r <= lin_uart_pkg::TX_IDLE;
                    end
                end
                lin_uart_pkg::TX_BREAK: begin
                    if (tx_bit_tick) begin
                        txd_out <= 1'b0;
                        tx_cnt_r <= tx_cnt_r - 4'h1;
                        if (tx_cnt_r == 4'h1) begin
                            tx_st_r <= ctrl2_r[`CTRL2_SBK] ? lin_uart_pkg::TX_BREAK
                                                            : lin_uart_pkg::TX_MARK;
                            tx_cnt_r <= ctrl2_r[`CTRL2_SBK] ? frame_len : 4'h1;
                        end
                    end
                end
                lin_uart_pkg::TX_MARK: begin
                    if (tx_bit_tick) begin
                        txd_out <= 1'b1;
                        tx_st_r <= lin_uart_pkg::TX_IDLE;
                    end
                end
                default: tx_st_r <= lin_uart_pkg::TX_IDLE;
            endcase
        end
    end

    // holding buffer and transmit flags
    logic tx_load;
    assign tx_load = tx_st_r == lin_uart_pkg::TX_IDLE && ctrl2_r[`CTRL2_TE] && !preamble_pend_r
                     && !ctrl2_r[`CTRL2_SBK] && hold_valid_r;
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            status_seen_r <= 1'b0;
        end else if (rd_status) begin
            status_seen_r <= 1'b1;
        end else if (wr_data) begin
            status_seen_r <= 1'b0;
        end
    end
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            hold_valid_r <= 1'b0;
            tx_hold_r <= 8'h00;
        end else if (te_rise || (req.wr && req.addr == `ADDR_CTRL2 && !req.wdata[`CTRL2_TE])) begin
            hold_valid_r <= 1'b0;
        end else if (wr_data) begin
            hold_valid_r <= 1'b1;
            tx_hold_r <= req.wdata;
        end else if (tx_load) begin
            hold_valid_r <= 1'b0;
        end
    end
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            tx_empty_r <= 1'b1;
        end else if (tx_load || !hold_valid_r && !wr_data) begin
            tx_empty_r <= 1'b1;
        end else if (wr_data && status_seen_r) begin
            tx_empty_r <= 1'b0;
        end
    end
    logic tx_frame_done;
    assign tx_frame_done = tx_st_r == lin_uart_pkg::TX_SHIFT && tx_word_end;
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            tx_done_r <= 1'b1;
        end else if (tx_frame_done) begin
            tx_done_r <= 1'b1;
        end else if (wr_data && status_seen_r) begin
            tx_done_r <= 1'b0;
        end
    end

    // receiver
    lin_uart_pkg::rx_state_t rx_st_r;
    lin_uart_pkg::hdr_state_t hdr_r;
    logic [3:0] rx_os_r, rx_bits_r;
    logic [8:0] rx_sh_r;
    logic rx_done, rx_stop_ok, rx_is_break;
    logic [8:0] rx_word;
    always_ff @(posedge clk_in) begin
        if (srst_in || !ctrl2_r[`CTRL2_RE]) begin
            rx_st_r <= lin_uart_pkg::RX_IDLE;
            rx_os_r <= 4'h0;
            rx_bits_r <= 4'h0;
            rx_sh_r <= 9'h000;
        end else if (rx_tick16) begin
            unique case (rx_st_r)
                lin_uart_pkg::RX_IDLE: begin
                    if (!rxd_in && rx_os_r != 4'hf) begin
                        rx_os_r <= rx_os_r + 4'h1;
                        if (rx_os_r == 4'h7) begin
                            rx_st_r <= lin_uart_pkg::RX_DATA;
                            rx_os_r <= 4'h0;
                            rx_bits_r <= word9 ? 4'h9 : 4'h8;
                        end
                    end else if (rxd_in) begin
                        rx_os_r <= 4'h0;
                    end
                end
                lin_uart_pkg::RX_DATA: begin
                    rx_os_r <= rx_os_r + 4'h1;
                    if (rx_os_r == 4'hf) begin
                        rx_sh_r <= word9 ? {rxd_in, rx_sh_r[8:1]} : {1'b0, rxd_in, rx_sh_r[7:1]};
                        rx_bits_r <= rx_bits_r - 4'h1;
                        if (rx_bits_r == 4'h1) rx_st_r <= lin_uart_pkg::RX_STOP;
                    end
                end
                lin_uart_pkg::RX_STOP: begin
                    rx_os_r <= (rx_os_r == 4'hf && !rxd_in) ? 4'hf : rx_os_r + 4'h1; // wait for line high
                    if (rx_os_r == 4'hf) rx_st_r <= lin_uart_pkg::RX_IDLE;
                end
                default: rx_st_r <= lin_uart_pkg::RX_IDLE;
            endcase
        end
    end
    assign rx_done = rx_tick16 && rx_st_r == lin_uart_pkg::RX_STOP && rx_os_r == 4'hf;
    assign rx_stop_ok = rxd_in;
    assign rx_word = rx_sh_r;
    assign rx_is_break = !rx_stop_ok && rx_word == 9'h000;

    // lin header tracking
    logic lin_on, id_char, hdr_evt, store_char, resync;
    logic [7:0] id_val;
    logic p0, p1, par_bad;
    assign lin_on = ctrl3_r[`CTRL3_LINE];
    assign resync = ctrl3_r[`CTRL3_RESYNC];
    assign id_char = rx_done && hdr_r == lin_uart_pkg::HDR_ID && !rx_is_break;
    assign id_val = word9 ? rx_word[7:0] : {rx_word[7:6], rx_word[5:0]};
    assign p0 = id_val[0] ^ id_val[1] ^ id_val[2] ^ id_val[4];
    assign p1 = ~(id_val[1] ^ id_val[3] ^ id_val[4] ^ id_val[5]);
    assign par_bad = word9 ? (p0 != rx_word[7] || p1 != rx_word[8])
                           : (p0 != rx_word[6] || p1 != rx_word[7]);
    always_ff @(posedge clk_in) begin
        if (srst_in || !lin_on) begin
            hdr_r <= lin_uart_pkg::HDR_WAIT;
        end else if (rx_done) begin
            if (rx_is_break) hdr_r <= lin_uart_pkg::HDR_SYNC;
            else if (hdr_r == lin_uart_pkg::HDR_SYNC) hdr_r <= lin_uart_pkg::HDR_ID;
            else hdr_r <= lin_uart_pkg::HDR_WAIT;
        end
    end
    always_comb begin
        hdr_evt = 1'b0;
        store_char = 1'b0;
        if (rx_done) begin
            if (!lin_on) begin
                store_char = 1'b1;
            end else if (rx_is_break) begin
                hdr_evt = !ctrl3_r[`CTRL3_HDSEL];
                store_char = !ctrl3_r[`CTRL3_HDSEL];
            end else if (hdr_r == lin_uart_pkg::HDR_SYNC) begin
                store_char = !resync && !ctrl3_r[`CTRL3_HDSEL];
            end else if (id_char) begin
                hdr_evt = ctrl3_r[`CTRL3_HDSEL];
                store_char = 1'b1;
            end else begin
                store_char = 1'b1;
            end
        end
    end
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rx_data_r <= 8'h00;
        end else if (store_char) begin
            rx_data_r <= rx_word[7:0];
        end
    end
    logic rd_data;
    assign rd_data = req.rd && req.addr == `ADDR_DATA;
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rx_full_r <= 1'b0;
        end else if (store_char) begin
            rx_full_r <= 1'b1;
        end else if (rd_data && status_seen_r) begin
            rx_full_r <= 1'b0;
        end
    end
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            frame_err_r <= 1'b0;
        end else if (rx_done && !rx_stop_ok && !(lin_slave && rx_is_break)) begin
            frame_err_r <= 1'b1;
        end else if (rd_data && status_seen_r) begin
            frame_err_r <= 1'b0;
        end
    end
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            par_err_r <= 1'b0;
        end else if (id_char && lin_slave && ctrl1_r[`CTRL1_PARITY] && par_bad) begin
            par_err_r <= 1'b1;
        end else if (rd_data && status_seen_r) begin
            par_err_r <= 1'b0;
        end
    end
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ctrl3_r <= 8'h00;
        end else begin
            if (req.wr && req.addr == `ADDR_CTRL3) begin
                ctrl3_r <= {req.wdata[7:2], ctrl3_r[1] & req.wdata[1], req.wdata[0]};
            end
            if (hdr_evt) ctrl3_r[`CTRL3_HFOUND] <= 1'b1;
        end
    end

    // read data and interrupt
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rdata_out <= 8'h00;
        end else if (req.rd) begin
            unique case (req.addr)
                `ADDR_STATUS: rdata_out <= {tx_empty_r, tx_done_r, rx_full_r, 3'b000, frame_err_r, par_err_r};
                `ADDR_DATA: rdata_out <= rx_data_r;
                `ADDR_BAUD: rdata_out <= baud_r;
                `ADDR_CTRL1: rdata_out <= ctrl1_r;
                `ADDR_CTRL2: rdata_out <= ctrl2_r;
                `ADDR_CTRL3: rdata_out <= ctrl3_r;
                `ADDR_RXDIV: rdata_out <= rxdiv_r;
                `ADDR_TXDIV: rdata_out <= txdiv_r;
                default: rdata_out <= 8'h00;
            endcase
        end else begin
            rdata_out <= 8'h00;
        end
    end
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= (cpu_mask_in == 2'b00)
                && ((ctrl3_r[`CTRL3_HIE] && ctrl3_r[`CTRL3_HFOUND])
                    || (ctrl2_r[`CTRL2_COMPLETE_IRQ_ENABLE] && tx_done_r));
        end
    end
endmodule
`default_nettype wire

// *** lin_uart_break_header_rx_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "lin_uart_params.svh"
module lin_uart_break_header_rx_tb_top;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic [7:0] addr_in = 8'h00;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [1:0] cpu_mask_in = 2'b11;
    logic rxd_in;
    logic [7:0] rdata_out;
    logic txd_out;
    logic irq_out;
    logic go = 1'b0;
    logic brk = 1'b0;
    logic [7:0] byte_v = 8'h00;
    logic busy;
    logic [7:0] s;
    logic [8:0] d;
    logic stp;
    int wt;
    int n_errors = 0;
    int checked = 0;
    int cyc = 0;
    logic [7:0] ra [7] = '{8'h40, 8'h42, 8'h44, 8'h45, 8'h46, 8'h47, 8'h50};
    logic [7:0] re [7] = '{8'hc0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    always #12.5 clk_in = ~clk_in;
    lin_uart_break_header_rx dut (.clk_in(clk_in), .srst_in(srst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .cpu_mask_in(cpu_mask_in), .rxd_in(rxd_in),
        .rdata_out(rdata_out), .txd_out(txd_out), .irq_out(irq_out));
    lin_node_model node (.clk_in(clk_in), .go_in(go), .brk_in(brk), .byte_in(byte_v), .line_out(rxd_in),
        .busy_out(busy));
    task automatic complete_run();
        if (n_errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chkb(input string nm, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("FAIL %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= v;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 v = rdata_out;
    endtask
    task automatic get_frame(input int nb, output logic [8:0] v, output logic sb, output int w);
        v = 9'h000;
        w = 0;
        while (txd_out !== 1'b0 && w < 2000) begin
            @(posedge clk_in);
            w++;
        end
        repeat (8) @(posedge clk_in);
        for (int i = 0; i < nb; i++) begin
            repeat (16) @(posedge clk_in);
            v[i] = txd_out;
        end
        repeat (16) @(posedge clk_in);
        sb = txd_out;
    endtask
    task automatic send(input logic b, input logic [7:0] v);
        @(posedge clk_in);
        go <= 1'b1;
        brk <= b;
        byte_v <= v;
        @(posedge clk_in);
        go <= 1'b0;
        for (int i = 0; i < 400; i++) begin
            @(posedge clk_in);
            if (i > 2 && busy === 1'b0) break;
        end
    endtask
    task automatic t_regs();
        for (int i = 0; i < 7; i++) begin
            rd(ra[i], s);
            chk8("reg_reset", re[i], s);
        end
        wr(`ADDR_RXDIV, 8'hff);
        rd(`ADDR_RXDIV, s);
        chk8("rx_div", 8'hff, s);
        wr(`ADDR_TXDIV, 8'h01);
        rd(`ADDR_TXDIV, s);
        chk8("tx_div", 8'h01, s);
        wr(`ADDR_RXDIV, 8'h00);
        wr(`ADDR_TXDIV, 8'h00);
        wr(`ADDR_CTRL1, 8'h80);
        rd(`ADDR_CTRL1, s);
        chkb("ctrl1_b7", 1'b0, s[7]);
        wr(`ADDR_CTRL1, 8'h00);
    endtask
    task automatic t_tx();
        wr(`ADDR_CTRL2, 8'h08);
        rd(`ADDR_STATUS, s);
        wr(`ADDR_DATA, 8'ha5);
        get_frame(8, d, stp, wt);
        chkb("preamble", 1'b1, wt >= 150);
        chk8("frame_a5", 8'ha5, d[7:0]);
        chkb("stop_a5", 1'b1, stp);
        repeat (12) @(posedge clk_in);
        rd(`ADDR_STATUS, s);
        chk8("flags_set", 8'hc0, s & 8'hc0);
        wr(`ADDR_DATA, 8'h5a);
        rd(`ADDR_STATUS, s);
        chkb("complete_clr", 1'b0, s[6]);
        get_frame(8, d, stp, wt);
        chk8("frame_5a", 8'h5a, d[7:0]);
        repeat (12) @(posedge clk_in);
    endtask
    task automatic t_irq();
        wr(`ADDR_CTRL2, 8'h48);
        repeat (3) @(posedge clk_in);
        chkb("irq_masked", 1'b0, irq_out);
        cpu_mask_in <= 2'b00;
        repeat (3) @(posedge clk_in);
        chkb("irq_done", 1'b1, irq_out);
        rd(`ADDR_STATUS, s);
        wr(`ADDR_DATA, 8'hc3);
        repeat (2) @(posedge clk_in);
        chkb("irq_cleared", 1'b0, irq_out);
        get_frame(8, d, stp, wt);
        chk8("frame_c3", 8'hc3, d[7:0]);
        repeat (24) @(posedge clk_in);
        chkb("irq_again", 1'b1, irq_out);
        wr(`ADDR_CTRL2, 8'h08);
    endtask
    task automatic t_break();
        int run;
        run = 0;
        wr(`ADDR_CTRL2, 8'h09);
        wt = 0;
        while (txd_out !== 1'b0 && wt < 400) begin
            @(posedge clk_in);
            wt++;
        end
        repeat (330) begin
            @(posedge clk_in);
            run += (txd_out === 1'b0) ? 1 : 0;
        end
        chkb("break_held", 1'b1, run == 330);
        wr(`ADDR_CTRL2, 8'h08);
        run += 2;
        while (txd_out === 1'b0 && run < 600) begin
            @(posedge clk_in);
            run++;
        end
        chkb("break_len", 1'b1, run >= 470 && run <= 490);
        run = 0;
        repeat (16) begin
            @(posedge clk_in);
            run += (txd_out === 1'b1) ? 1 : 0;
        end
        chkb("mark_bit", 1'b1, run == 16);
    endtask
    task automatic t_nine();
        wr(`ADDR_CTRL1, 8'h50);
        rd(`ADDR_STATUS, s);
        wr(`ADDR_DATA, 8'h3c);
        get_frame(9, d, stp, wt);
        chk8("nine_low", 8'h3c, d[7:0]);
        chkb("nine_top", 1'b1, d[8]);
        chkb("nine_stop", 1'b1, stp);
        repeat (12) @(posedge clk_in);
        wr(`ADDR_CTRL1, 8'h00);
    endtask
    task automatic t_hdr_brk();
        wr(`ADDR_CTRL3, 8'h44);
        wr(`ADDR_CTRL2, 8'h0c);
        send(1'b1, 8'h00);
        rd(`ADDR_STATUS, s);
        chkb("brk_full", 1'b1, s[5]);
        rd(`ADDR_DATA, s);
        chk8("brk_data", 8'h00, s);
        rd(`ADDR_CTRL3, s);
        chkb("brk_found", 1'b1, s[1]);
        chkb("hdr_irq", 1'b1, irq_out);
        wr(`ADDR_CTRL3, 8'h44);
        send(1'b0, 8'h55);
        rd(`ADDR_STATUS, s);
        chkb("sync_full", 1'b1, s[5]);
        rd(`ADDR_DATA, s);
        chk8("sync_data", 8'h55, s);
    endtask
    task automatic t_hdr_id();
        wr(`ADDR_CTRL3, 8'h4c);
        send(1'b1, 8'h00);
        rd(`ADDR_STATUS, s);
        chkb("id_brk", 1'b0, s[5]);
        send(1'b0, 8'h55);
        rd(`ADDR_STATUS, s);
        chkb("id_sync", 1'b0, s[5]);
        send(1'b0, 8'h3a);
        rd(`ADDR_STATUS, s);
        chkb("id_full", 1'b1, s[5]);
        rd(`ADDR_DATA, s);
        chk8("id_data", 8'h3a, s);
        rd(`ADDR_CTRL3, s);
        chkb("id_found", 1'b1, s[1]);
    endtask
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 30000) begin
            n_errors++;
            complete_run();
        end
    end
    initial begin
        repeat (2) @(posedge clk_in);
        srst_in <= 1'b0;
        t_regs();
        t_tx();
        t_irq();
        t_break();
        t_nine();
        t_hdr_brk();
        t_hdr_id();
        complete_run();
    end
endmodule
`default_nettype wire

// *** lin_uart_checker_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "lin_uart_params.svh"
module lin_uart_checker (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [1:0] cpu_mask_in,
    input wire logic rxd_in,
    input wire logic [7:0] rdata_out,
    input wire logic txd_out,
    input wire logic irq_out
);
    logic tx_on_r;
    logic cie_r;
    logic hie_r;
    logic [7:0] pre_cnt_r;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (srst_in);
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            tx_on_r <= 1'b0;
            cie_r <= 1'b0;
        end else if (wr_in && addr_in == `ADDR_CTRL2) begin
            tx_on_r <= wdata_in[`CTRL2_TE];
            cie_r <= wdata_in[`CTRL2_COMPLETE_IRQ_ENABLE];
        end
    end
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            hie_r <= 1'b0;
        end else if (wr_in && addr_in == `ADDR_CTRL3) begin
            hie_r <= wdata_in[`CTRL3_HIE];
        end
    end
    // ones the line must hold after switching the transmitter on
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            pre_cnt_r <= 8'h00;
        end else if (wr_in && addr_in == `ADDR_CTRL2 && wdata_in[`CTRL2_TE] && !tx_on_r && txd_out) begin
            pre_cnt_r <= 8'h9f;
        end else if (pre_cnt_r != 8'h00) begin
            pre_cnt_r <= pre_cnt_r - 8'h01;
        end
    end
    a_reset_out: assert property (disable iff (1'b0) srst_in |=> txd_out && !irq_out && rdata_out == 8'h00)
        else $error("outputs not at reset level");
    a_rdata_stands: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
        else $error("read data outside its cycle");
    a_unmapped_zero: assert property (rd_in && (addr_in < 8'h40 || addr_in > 8'h47) |=> rdata_out == 8'h00)
        else $error("unmapped read not zero");
    a_ctrl1_top: assert property (rd_in && addr_in == `ADDR_CTRL1 |=> !rdata_out[7])
        else $error("control one bit 7 not zero");
    a_div_readback: assert property (wr_in && addr_in == `ADDR_RXDIV ##2 rd_in && addr_in == `ADDR_RXDIV
        |=> rdata_out == $past(wdata_in, 3))
        else $error("rx divider readback wrong");
    a_irq_masked: assert property ($past(cpu_mask_in) != 2'b00 |-> !irq_out)
        else $error("irq while masked");
    a_irq_cause: assert property ($rose(irq_out) |-> hie_r || cie_r)
        else $error("irq without enable");
    a_preamble_ones: assert property (pre_cnt_r != 8'h00 |-> txd_out)
        else $error("preamble broken");
    a_bit_width: assert property ($changed(txd_out) |=> $stable(txd_out) [*8])
        else $error("line bit too short");
    a_break_low: assert property (wr_in && addr_in == `ADDR_CTRL2 && wdata_in[`CTRL2_SBK] && tx_on_r
        |-> ##[1:400] !txd_out)
        else $error("break not sent");
    c_irq: cover property ($rose(irq_out));
    c_preamble: cover property (pre_cnt_r == 8'h01);
    c_status: cover property (rd_in && addr_in == `ADDR_STATUS);
endmodule
bind lin_uart_break_header_rx lin_uart_checker chk_i (.clk_in, .srst_in, .addr_in, .wdata_in, .wr_in,
    .rd_in, .cpu_mask_in, .rxd_in, .rdata_out, .txd_out, .irq_out);
`default_nettype wire

// *** lin_uart_params.svh ***
`ifndef LIN_UART_PARAMS_SVH
`define LIN_UART_PARAMS_SVH
`define ADDR_STATUS 8'h40
`define ADDR_DATA 8'h41
`define ADDR_BAUD 8'h42
`define ADDR_CTRL1 8'h43
`define ADDR_CTRL2 8'h44
`define ADDR_CTRL3 8'h45
`define ADDR_RXDIV 8'h46
`define ADDR_TXDIV 8'h47
`define STATUS_RESET 8'hc0
`define CTRL1_WORD9 4
`define CTRL1_NINTH 6
`define CTRL1_PARITY 2
`define CTRL2_COMPLETE_IRQ_ENABLE 6
`define CTRL2_TE 3
`define CTRL2_RE 2
`define CTRL2_SBK 0
`define CTRL3_LINE 6
`define CTRL3_SLAVE 5
`define CTRL3_RESYNC 4
`define CTRL3_HDSEL 3
`define CTRL3_HIE 2
`define CTRL3_HFOUND 1
`define OVERSAMPLE 8'h10
`define PREAMBLE_8 4'ha
`define PREAMBLE_9 4'hb
`endif

// *** lin_uart_pkg.sv ***
`default_nettype none
package lin_uart_pkg;
    typedef enum logic [2:0] {TX_IDLE, TX_PREAMBLE, TX_SHIFT, TX_BREAK, TX_MARK} tx_state_t;
    typedef enum logic [2:0] {RX_IDLE, RX_DATA, RX_STOP} rx_state_t;
    typedef enum logic [1:0] {HDR_WAIT, HDR_SYNC, HDR_ID} hdr_state_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;
endpackage
`default_nettype wire
